// ---- core/zsm_pkg.sv ----
// constants, types and helpers of the standstill watch block
// Function
// R01: both encoder inputs low signals wire break and removes the standstill enable.
// R02: both inputs changing in the same cycle signals a fault and withdraws enable; the code faults only when both change to the same level.
// R03: after reset equal input levels raise no fault until a first edge appears.
// R04: after a first edge, equal input levels raise a fault and open the enable.
// R05: auto start holds the enable closed after reset until the first edge.
// R06: measured frequency above the standstill limit withdraws the enable.
// R07: manual or controlled start re-issues enable only after restart coil pulse.
// R08: manual or controlled start needs frequency 5% below limit before re-issue.
// R09: auto start re-issues enable at once when frequency falls 5% below limit.
// R10: frequency above 1000 Hz or a failed sensor channel is an error.
// R11: errors stay latched until the safety activation coil drops out.
// R12: a diagnostic word reports wait, standstill and error states by code.
// R13: standstill limit is 2 to 50 Hz in 1 Hz steps, defaulting to 2 Hz.
// R14: block runs freely by default, else only while the enable coil is set.
// R15: restart coil starts normal operation in manual and controlled start modes.
// R16: each channel counts edges over a fixed gate; both results are compared.
package zsm_pkg;

    // timing of the measuring gate
    localparam int CLK_PERIOD_NS = 10;
    localparam int GATE_TIME_NS = 1_000_000_000;
    localparam int GATE_CYCLES = GATE_TIME_NS / CLK_PERIOD_NS;
    localparam int GATE_W = 27;

    // frequency ranges
    localparam int FREQ_W = 12;
    localparam int LIMIT_W = 6;
    localparam int MAX_FREQ_HZ = 1000;
    localparam logic [LIMIT_W-1:0] LIMIT_MIN_HZ = 6'h02;
    localparam logic [LIMIT_W-1:0] LIMIT_MAX_HZ = 6'h32;
    localparam logic [LIMIT_W-1:0] LIMIT_DEFAULT_HZ = 6'h02;
    localparam int HYST_NUM = 19;
    localparam int HYST_DEN = 20;
    localparam int MISMATCH_SHIFT = 3;

    // diagnostic codes
    localparam logic [15:0] DIAG_NO_ENABLE = 16'h0000;
    localparam logic [15:0] DIAG_WAIT_SA = 16'h2001;
    localparam logic [15:0] DIAG_WAIT_RE_RISE = 16'h2003;
    localparam logic [15:0] DIAG_WAIT_RE_FALL = 16'h2004;
    localparam logic [15:0] DIAG_MEASURING = 16'h2009;
    localparam logic [15:0] DIAG_STANDSTILL = 16'h8010;
    localparam logic [15:0] DIAG_ERR_WIRE_BREAK = 16'hF007;
    localparam logic [15:0] DIAG_ERR_RANGE = 16'hF008;
    localparam logic [15:0] DIAG_ERR_MISMATCH = 16'hF009;
    localparam logic [15:0] DIAG_ERR_NO_PULSES = 16'hF00A;
    localparam logic [15:0] DIAG_ERR_RESTART_AT_START = 16'hF013;

    typedef enum logic [1:0] {
        AUTO_START_MODE = 2'h0,
        MANUAL_START_MODE = 2'h1,
        CONTROLLED_START_MODE = 2'h2
    } start_mode_t;

    // gray coded along idle, wait, measure, standstill
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_WAIT_SA = 3'h1,
        ST_MEASURE = 3'h3,
        ST_STANDSTILL = 3'h2,
        ST_WAIT_RE_RISE = 3'h6,
        ST_WAIT_RE_FALL = 3'h7,
        ST_ERROR = 3'h5
    } zsm_state_t;

    // frequency at least 5% below the limit
    function automatic logic below_hyst(input logic [FREQ_W-1:0] f,
                                        input logic [LIMIT_W-1:0] lim);
        logic [FREQ_W+5:0] lhs;
        logic [FREQ_W+5:0] rhs;
        lhs = (FREQ_W+6)'(f) * (FREQ_W+6)'(HYST_DEN);
        rhs = (FREQ_W+6)'(lim) * (FREQ_W+6)'(HYST_NUM);
        return lhs <= rhs;
    endfunction

    // out of range settings fall back to the default limit
    function automatic logic [LIMIT_W-1:0] clamp_limit(input logic [LIMIT_W-1:0] lim);
        if (lim < LIMIT_MIN_HZ || lim > LIMIT_MAX_HZ) begin
            return LIMIT_DEFAULT_HZ;
        end
        return lim;
    endfunction

endpackage

// ---- core/edge_freq_meter.sv ----
// rising edge counter over a gate window for one encoder channel
`timescale 1ns/100ps
module edge_freq_meter
    import zsm_pkg::*;
#(
    parameter int CNT_W = FREQ_W
) (
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    input wire logic level_i,
    input wire logic gate_tick_i,
    output logic [CNT_W-1:0] count_o
);

    logic prev_q;
    logic prev_d;
    logic [CNT_W-1:0] acc_q;
    logic [CNT_W-1:0] acc_d;
    logic [CNT_W-1:0] count_q;
    logic [CNT_W-1:0] count_d;
    logic rise;

    // count edges, hand result over at each gate tick
    always_comb begin
        rise = level_i & ~prev_q;
        prev_d = level_i;
        acc_d = acc_q;
        count_d = count_q;
        if (gate_tick_i) begin
            count_d = acc_q; // R16
            acc_d = {{(CNT_W-1){1'b0}}, rise};
        end else if (rise && acc_q != {CNT_W{1'b1}}) begin
            acc_d = acc_q + 1'b1; // saturating
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            prev_q <= 1'b0;
            acc_q <= '0;
            count_q <= '0;
        end else begin
            prev_q <= prev_d;
            acc_q <= acc_d;
            count_q <= count_d;
        end
    end

    assign count_o = count_q;

endmodule

// ---- core/standstill_watch_block.sv ----
// standstill monitor for a shaft sensed by two proximity sensors
`timescale 1ns/100ps
module standstill_watch_block
    import zsm_pkg::*;
#(
    parameter int GATE_LEN = GATE_CYCLES
) (
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    input wire logic encoder_input_a_i,
    input wire logic encoder_input_b_i,
    input wire logic restart_coil_i,
    input wire logic safety_activation_coil_i,
    input wire logic block_enable_coil_i,
    input wire logic no_external_enable_setting_i,
    input wire logic [1:0] start_mode_i,
    input wire logic [LIMIT_W-1:0] standstill_freq_limit_i,
    output logic standstill_enable_contact_o,
    output logic fault_contact_o,
    output logic [15:0] diagnostic_word_o,
    output logic [FREQ_W-1:0] measured_freq_output_o
);

    // pin synchronisers and edge history
    logic a_s1_q;
    logic a_s2_q;
    logic b_s1_q;
    logic b_s2_q;
    logic a_prev_q;
    logic b_prev_q;
    logic first_edge_q;
    logic first_edge_d;
    logic [2:0] edge_arm_q;
    logic [2:0] edge_arm_d;

    // gate timing
    logic [GATE_W-1:0] gate_cnt_q;
    logic [GATE_W-1:0] gate_cnt_d;
    logic gate_tick;
    logic meas_valid_q;
    logic meas_valid_d;
    logic [FREQ_W-1:0] cnt_a;
    logic [FREQ_W-1:0] cnt_b;

    // control state
    zsm_state_t state_q;
    zsm_state_t state_d;
    logic [15:0] err_q;
    logic [15:0] err_d;
    logic en_q;
    logic en_d;
    logic flt_q;
    logic flt_d;
    logic [15:0] diag_q;
    logic [15:0] diag_d;
    logic [FREQ_W-1:0] freq_q;
    logic [FREQ_W-1:0] freq_d;

    // derived conditions
    logic a_edge;
    logic b_edge;
    logic active;
    logic auto_mode;
    logic [LIMIT_W-1:0] limit;
    logic [FREQ_W-1:0] f_max;
    logic [FREQ_W-1:0] f_min;
    logic hyst_ok;
    logic over_limit;
    logic fault_now;
    logic [15:0] fault_code;
    logic running;

    // two flops on each pin before any use
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            a_s1_q <= 1'b0;
            a_s2_q <= 1'b0;
            b_s1_q <= 1'b0;
            b_s2_q <= 1'b0;
            a_prev_q <= 1'b0;
            b_prev_q <= 1'b0;
        end else begin
            a_s1_q <= encoder_input_a_i;
            a_s2_q <= a_s1_q;
            b_s1_q <= encoder_input_b_i;
            b_s2_q <= b_s1_q;
            a_prev_q <= a_s2_q;
            b_prev_q <= b_s2_q;
        end
    end

    // edge seen flag and gate counter
    always_comb begin
        // edges count only once the history flop holds a real pin sample
        edge_arm_d = {edge_arm_q[1:0], 1'b1};
        a_edge = (a_s2_q ^ a_prev_q) & edge_arm_q[2]; // R03
        b_edge = (b_s2_q ^ b_prev_q) & edge_arm_q[2];
        first_edge_d = first_edge_q | a_edge | b_edge; // R03
        gate_tick = (gate_cnt_q == GATE_W'(GATE_LEN - 1));
        gate_cnt_d = gate_tick ? '0 : gate_cnt_q + 1'b1;
        meas_valid_d = meas_valid_q | gate_tick;
    end

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            first_edge_q <= 1'b0;
            edge_arm_q <= '0;
            gate_cnt_q <= '0;
            meas_valid_q <= 1'b0;
        end else begin
            first_edge_q <= first_edge_d;
            edge_arm_q <= edge_arm_d;
            gate_cnt_q <= gate_cnt_d;
            meas_valid_q <= meas_valid_d;
        end
    end

    // per channel edge counters
    edge_freq_meter #(.CNT_W(FREQ_W)) u_meter_a (
        .sys_clk_i(sys_clk_i),
        .sys_rst_i(sys_rst_i),
        .level_i(a_s2_q),
        .gate_tick_i(gate_tick),
        .count_o(cnt_a)
    );

    edge_freq_meter #(.CNT_W(FREQ_W)) u_meter_b (
        .sys_clk_i(sys_clk_i),
        .sys_rst_i(sys_rst_i),
        .level_i(b_s2_q),
        .gate_tick_i(gate_tick),
        .count_o(cnt_b)
    );

    // frequency compare and fault classification
    always_comb begin
        active = no_external_enable_setting_i | block_enable_coil_i; // R14
        auto_mode = (start_mode_i == AUTO_START_MODE);
        limit = clamp_limit(standstill_freq_limit_i); // R13
        f_max = (cnt_a > cnt_b) ? cnt_a : cnt_b; // R16
        f_min = (cnt_a > cnt_b) ? cnt_b : cnt_a;
        hyst_ok = meas_valid_q && below_hyst(f_max, limit); // R08 R09
        over_limit = meas_valid_q && (f_max > FREQ_W'(limit)); // R06
        fault_now = 1'b1;
        fault_code = DIAG_ERR_WIRE_BREAK;
        if (first_edge_q && !a_s2_q && !b_s2_q) begin
            fault_code = DIAG_ERR_WIRE_BREAK; // R01
        end else if (a_edge && b_edge && a_s2_q == b_s2_q) begin // in-phase change
            fault_code = DIAG_ERR_MISMATCH; // R02
        end else if (first_edge_q && a_s2_q == b_s2_q) begin
            fault_code = DIAG_ERR_MISMATCH; // R04
        end else if (meas_valid_q && f_max > FREQ_W'(MAX_FREQ_HZ)) begin
            fault_code = DIAG_ERR_RANGE; // R10
        end else if (meas_valid_q && f_min == '0 && f_max > FREQ_W'(1)) begin
            fault_code = DIAG_ERR_NO_PULSES; // R10
        end else if (meas_valid_q && (f_max - f_min) > ((f_max >> MISMATCH_SHIFT) + 1'b1)) begin
            fault_code = DIAG_ERR_MISMATCH; // R16
        end else begin
            fault_now = 1'b0;
        end
    end

    // sequencing of enable, restart and errors
    always_comb begin
        state_d = state_q;
        err_d = err_q;
        running = 1'b0;
        case (state_q)
            ST_IDLE: begin
                if (active) begin
                    state_d = ST_WAIT_SA;
                end
            end
            ST_WAIT_SA: begin
                if (!active) begin
                    state_d = ST_IDLE;
                end else if (safety_activation_coil_i) begin
                    if (!auto_mode && restart_coil_i) begin
                        state_d = ST_ERROR;
                        err_d = DIAG_ERR_RESTART_AT_START;
                    end else begin
                        state_d = ST_MEASURE;
                    end
                end
            end
            ST_MEASURE: begin
                running = 1'b1;
                if (auto_mode && !first_edge_q) begin
                    state_d = ST_STANDSTILL; // R05
                end else if (hyst_ok) begin
                    state_d = auto_mode ? ST_STANDSTILL : ST_WAIT_RE_RISE; // R09 R08
                end
            end
            ST_WAIT_RE_RISE: begin
                running = 1'b1;
                if (restart_coil_i) begin
                    state_d = ST_WAIT_RE_FALL; // R07 R15
                end
            end
            ST_WAIT_RE_FALL: begin
                running = 1'b1;
                if (!restart_coil_i) begin
                    state_d = hyst_ok ? ST_STANDSTILL : ST_MEASURE; // R07 R08
                end
            end
            ST_STANDSTILL: begin
                running = 1'b1;
                if (over_limit) begin
                    state_d = ST_MEASURE; // R06
                end
            end
            ST_ERROR: begin
                if (!safety_activation_coil_i) begin
                    state_d = ST_WAIT_SA; // R11
                    err_d = DIAG_NO_ENABLE;
                end
            end
            default: begin
                state_d = ST_IDLE;
                err_d = DIAG_NO_ENABLE;
            end
        endcase
        if (running) begin
            if (!active) begin
                state_d = ST_IDLE;
            end else if (!safety_activation_coil_i) begin
                state_d = ST_WAIT_SA;
            end else if (fault_now) begin
                state_d = ST_ERROR; // R10 R11
                err_d = fault_code;
            end
        end
    end

    // registered outputs follow the next state, the frequency output follows f_max
    always_comb begin
        en_d = (state_d == ST_STANDSTILL);
        flt_d = (state_d == ST_ERROR);
        freq_d = f_max;
        case (state_d)
            ST_IDLE: diag_d = DIAG_NO_ENABLE; // R12
            ST_WAIT_SA: diag_d = DIAG_WAIT_SA;
            ST_MEASURE: diag_d = DIAG_MEASURING;
            ST_WAIT_RE_RISE: diag_d = DIAG_WAIT_RE_RISE;
            ST_WAIT_RE_FALL: diag_d = DIAG_WAIT_RE_FALL;
            ST_STANDSTILL: diag_d = DIAG_STANDSTILL;
            ST_ERROR: diag_d = err_d;
            default: diag_d = DIAG_NO_ENABLE;
        endcase
    end

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            state_q <= ST_IDLE;
            err_q <= DIAG_NO_ENABLE;
            en_q <= 1'b0;
            flt_q <= 1'b0;
            diag_q <= DIAG_NO_ENABLE;
            freq_q <= '0;
        end else begin
            state_q <= state_d;
            err_q <= err_d;
            en_q <= en_d;
            flt_q <= flt_d;
            diag_q <= diag_d;
            freq_q <= freq_d;
        end
    end

    assign standstill_enable_contact_o = en_q;
    assign fault_contact_o = flt_q;
    assign diagnostic_word_o = diag_q;
    assign measured_freq_output_o = freq_q;

endmodule

// ---- dv/standstill_watch_block_props.sv ----
// assertion checker of the standstill watch block
`timescale 1ns/100ps
module standstill_watch_block_props
    import zsm_pkg::*;
#(
    parameter int GATE_LEN = GATE_CYCLES
) (
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    input wire logic encoder_input_a_i,
    input wire logic encoder_input_b_i,
    input wire logic restart_coil_i,
    input wire logic safety_activation_coil_i,
    input wire logic block_enable_coil_i,
    input wire logic no_external_enable_setting_i,
    input wire logic [1:0] start_mode_i,
    input wire logic [LIMIT_W-1:0] standstill_freq_limit_i,
    input wire logic standstill_enable_contact_o,
    input wire logic fault_contact_o,
    input wire logic [15:0] diagnostic_word_o,
    input wire logic [FREQ_W-1:0] measured_freq_output_o
);
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (sys_rst_i);

    // fault, enable and status word stay consistent
    a_fault_opens: assert property (fault_contact_o |-> !standstill_enable_contact_o)
        else $error("enable closed with fault");
    a_fault_code: assert property (fault_contact_o |-> diagnostic_word_o[15:12] == 4'hf)
        else $error("fault without error word");
    a_enable_code: assert property (standstill_enable_contact_o |->
        diagnostic_word_o == DIAG_STANDSTILL) else $error("enable without standstill word");

    // coils and settings
    a_idle_off: assert property (!no_external_enable_setting_i && !block_enable_coil_i
        |=> !standstill_enable_contact_o) else $error("enable while block inactive");
    a_sa_clears: assert property (!safety_activation_coil_i |=>
        !standstill_enable_contact_o && !fault_contact_o) else $error("not cleared by coil");
    a_error_held: assert property (fault_contact_o && safety_activation_coil_i
        |=> fault_contact_o) else $error("fault dropped with coil held");
    a_restart_gap: assert property ($rose(standstill_enable_contact_o) && start_mode_i != 2'h0
        |-> !restart_coil_i && ($past(restart_coil_i) || $past(restart_coil_i, 2)))
        else $error("enable without restart pulse");

    // frequency limits
    a_over_limit: assert property (standstill_enable_contact_o
        && standstill_freq_limit_i >= LIMIT_MIN_HZ && standstill_freq_limit_i <= LIMIT_MAX_HZ
        && measured_freq_output_o > 12'(standstill_freq_limit_i)
        |-> ##[0:2] !standstill_enable_contact_o) else $error("enable kept above limit");
    a_over_range: assert property ((safety_activation_coil_i && no_external_enable_setting_i
        && measured_freq_output_o > 12'(MAX_FREQ_HZ))[*4] |-> fault_contact_o)
        else $error("overrange not flagged");

    // main scenarios reached
    c_reissue: cover property ($rose(standstill_enable_contact_o));
    c_fault: cover property ($rose(fault_contact_o));
    c_wait_fall: cover property (diagnostic_word_o == DIAG_WAIT_RE_FALL);
endmodule

bind standstill_watch_block standstill_watch_block_props #(.GATE_LEN(GATE_LEN)) props_i (
    .sys_clk_i, .sys_rst_i, .encoder_input_a_i, .encoder_input_b_i, .restart_coil_i,
    .safety_activation_coil_i, .block_enable_coil_i, .no_external_enable_setting_i,
    .start_mode_i, .standstill_freq_limit_i, .standstill_enable_contact_o, .fault_contact_o,
    .diagnostic_word_o, .measured_freq_output_o);

// ---- dv/sensor_pair_model.sv ----
// proximity sensor pair sensing a cam wheel
`timescale 1ns/100ps
module sensor_pair_model (
    input wire logic sys_clk_i,
    input wire logic [11:0] half_i,
    input wire logic [1:0] flaw_i,
    output logic sens_a_o,
    output logic sens_b_o
);
    logic cam_q = 1'b0;
    int ticks = 0;

    // cam advances every half period, a still shaft keeps its position
    always @(negedge sys_clk_i) begin
        if (half_i == 12'h000) begin
            ticks = 0;
        end else if (++ticks >= int'(half_i)) begin
            ticks = 0;
            cam_q = ~cam_q;
        end
    end

    // sound sensors are complementary, flaws only on command
    always_comb begin
        case (flaw_i)
            2'h1: {sens_a_o, sens_b_o} = 2'b00;
            2'h2: {sens_a_o, sens_b_o} = 2'b11;
            2'h3: {sens_a_o, sens_b_o} = {cam_q, cam_q};
            default: {sens_a_o, sens_b_o} = {cam_q, ~cam_q};
        endcase
    end
endmodule

// ---- dv/standstill_watch_block_tb_top.sv ----
// self-checking bench of the standstill watch block
`timescale 1ns/100ps
module standstill_watch_block_tb_top;
    import zsm_pkg::*;
    localparam int GL = 4000;
    logic clk = 1'b0, rst = 1'b1, re = 1'b0, sa = 1'b0, blk = 1'b0, free_run = 1'b1;
    logic [1:0] mode = 2'h0, flaw = 2'h0;
    logic [5:0] lim = 6'h14;
    logic [11:0] half = 12'h000;
    logic a, b, en, flt;
    logic [15:0] diag;
    logic [11:0] freq;
    int errors = 0;
    int n_compared = 0;

    // clock
    initial begin
        forever #5 clk = ~clk;
    end

    sensor_pair_model sensor_pair_model_i (.sys_clk_i(clk), .half_i(half), .flaw_i(flaw),
        .sens_a_o(a), .sens_b_o(b));
    standstill_watch_block #(.GATE_LEN(GL)) standstill_watch_block_i (.sys_clk_i(clk),
        .sys_rst_i(rst), .encoder_input_a_i(a), .encoder_input_b_i(b), .restart_coil_i(re),
        .safety_activation_coil_i(sa), .block_enable_coil_i(blk),
        .no_external_enable_setting_i(free_run), .start_mode_i(mode),
        .standstill_freq_limit_i(lim),
        .standstill_enable_contact_o(en), .fault_contact_o(flt), .diagnostic_word_o(diag),
        .measured_freq_output_o(freq));

    // expectations
    function automatic logic [11:0] gate_count(input int h);
        return 12'(GL / (2 * h));
    endfunction
    function automatic logic near(input logic [11:0] f, input int h);
        return f + 12'h001 >= gate_count(h) && f <= gate_count(h) + 12'h001;
    endfunction
    function automatic logic reissue_ok(input logic [11:0] f, input logic [5:0] l);
        return 32'(f) * 20 <= 32'(l) * 19;
    endfunction
    function automatic logic [15:0] fault_word(input int k);
        return (k == 1) ? DIAG_ERR_WIRE_BREAK : DIAG_ERR_MISMATCH;
    endfunction

    // comparison, waiting and sequencing helpers
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic restart(input logic [1:0] m);
        rst = 1'b1;
        {sa, re, blk, free_run} = 4'b0001;
        half = 12'h000;
        flaw = 2'h0;
        mode = m;
        cyc(2);
        rst = 1'b0;
        cyc(1);
    endtask
    task automatic pulse_restart();
        re = 1'b1;
        cyc(2);
        check(diag, DIAG_WAIT_RE_FALL);
        re = 1'b0;
        cyc(2);
    endtask
    task automatic conclude();
        $display("compared %0d, mismatched %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // watchdog beyond the planned run
    initial begin
        repeat (90000) @(posedge clk);
        errors++;
        conclude();
    end

    // main sequence
    initial begin
        void'($urandom(32'h0000_f61c));
        cyc(2);
        check(diag, DIAG_NO_ENABLE);
        check(16'({en, flt, freq}), 16'h0000);
        rst = 1'b0;
        cyc(1);
        check(diag, DIAG_WAIT_SA);
        // auto start: static levels from reset, then fast and slow shaft
        lim = 6'(20 + $urandom_range(10));
        for (int q = 1; q < 3; q++) begin
            rst = 1'b1;
            flaw = 2'(q);
            cyc(2);
            rst = 1'b0;
            sa = 1'b1;
            cyc(6);
            check(diag, DIAG_STANDSTILL);
            check(16'(flt), 16'h0000);
            if (q == 1) begin
                // both pins rising together before any first edge
                flaw = 2'h2;
                cyc(6);
                check(diag, DIAG_ERR_MISMATCH);
            end
        end
        flaw = 2'h0;
        half = 12'h032;
        cyc(2 * GL + 20);
        check(16'(en), 16'h0000);
        check(16'(near(freq, 50)), 16'h0001);
        half = 12'h0c8;
        cyc(2 * GL + 20);
        check(16'(en), 16'(reissue_ok(gate_count(200), lim)));
        // sensor faults latch until the activation coil drops
        for (int k = 1; k < 4; k++) begin
            restart(2'h0);
            sa = 1'b1;
            half = 12'h03c;
            cyc(200);
            flaw = 2'(k);
            cyc(10);
            check(diag, fault_word(k));
            check(16'({flt, en}), 16'h0002);
            flaw = 2'h0;
            cyc(10);
            check(16'(flt), 16'h0001);
            sa = 1'b0;
            cyc(3);
            check(diag, DIAG_WAIT_SA);
        end
        // shaft above the measuring range
        restart(2'h0);
        sa = 1'b1;
        half = 12'h001;
        cyc(GL + 20);
        check(diag, DIAG_ERR_RANGE);
        // restart coil walk in manual and controlled start
        for (int m = 1; m < 3; m++) begin
            restart(2'(m));
            free_run = 1'b0;
            sa = 1'b1;
            cyc(3);
            check(diag, DIAG_NO_ENABLE);
            blk = 1'b1;
            cyc(GL);
            check(diag, DIAG_WAIT_RE_RISE);
            pulse_restart();
            check(diag, DIAG_STANDSTILL);
            half = 12'h032;
            cyc(2 * GL + 20);
            check(16'(en), 16'h0000);
            half = 12'h0c8;
            cyc(2 * GL + 20);
            check(diag, DIAG_WAIT_RE_RISE);
            pulse_restart();
            check(16'(en), 16'h0001);
            // lower limit in range, then out of range falling back to 2 Hz
            lim = (m == 1) ? 6'h05 : 6'h3f;
            cyc(3);
            check(16'(en), 16'h0000);
            lim = 6'(20 + $urandom_range(10));
            re = 1'b1;
            sa = 1'b0;
            cyc(2);
            sa = 1'b1;
            cyc(3);
            check(diag, DIAG_ERR_RESTART_AT_START);
        end
        conclude();
    end
endmodule
